// >>> logic/uart_buf_pkg.sv
package uart_buf_pkg;
    // Register byte offsets
    localparam logic [4:0] OFF_DATA   = 5'h00;
    localparam logic [4:0] OFF_STAT_A = 5'h04;
    localparam logic [4:0] OFF_STAT_B = 5'h08;
    localparam logic [4:0] OFF_FRAME  = 5'h0c;
    localparam logic [4:0] OFF_BAUD   = 5'h10;
    // ctrl_status_first bits
    localparam int A_RXC  = 7;
    localparam int A_TXC  = 6;
    localparam int A_TXE  = 5;
    localparam int A_FE   = 4;
    localparam int A_DOR  = 3;
    localparam int A_PE   = 2;
    // ctrl_status_second bits
    localparam int B_RXCIE = 7;
    localparam int B_TXCIE = 6;
    localparam int B_TXEIE = 5;
    localparam int B_RXEN  = 4;
    localparam int B_TXEN  = 3;
    localparam int B_SIZE2 = 2;
    localparam int B_RX9   = 1;
    localparam int B_TX9   = 0;
    // Frame register bits
    localparam int F_PODD  = 0;
    localparam int F_PEN   = 1;
    localparam int F_STOP2 = 2;
    localparam int F_SIZE  = 3;
    localparam int F_SYNC  = 5;
    // Reset values and codes
    localparam logic [2:0]  SIZE_NINE   = 3'h7;
    localparam logic [1:0]  SIZE_LO_RST = 2'h3;
    localparam logic [11:0] BAUD_RST    = 12'h00f;
    localparam int          BAUD_W      = 12;
    localparam int          ENT_W       = 12;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } tx_st_e;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } rx_st_e;
endpackage : uart_buf_pkg

// >>> logic/uart_buffer_flags_and_irqs.sv
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module uart_buffer_flags_and_irqs #(
    parameter int RX_DEPTH = 2
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins
    input  wire logic        serial_in_pin,
    input  wire logic        transfer_clock_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    output logic             serial_in_takeover,
    // Interrupt requests
    input  wire logic        tx_complete_irq_ack,
    output logic             tx_empty_irq,
    output logic             tx_complete_irq,
    output logic             rx_complete_irq
);
    localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW+1)'(RX_DEPTH);

    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_depth_bad
        $error("RX_DEPTH must be a power of two, at least 2");
    end

    // Control registers
    logic rxcie_r, txcie_r, txeie_r, rx_en_r, tx_en_r, size2_r, tx9_r;
    logic par_en_r, par_odd_r, stop2_r, sync_r;
    logic [1:0]  size_lo_r;
    logic [11:0] baud_r;
    // Bus data phase
    logic        dp_valid_r, dp_write_r, rd_done_r;
    logic [4:0]  dp_addr_r;
    logic [31:0] hrdata_r;
    // Flags and buffers
    logic        txb_valid_r, tx_complete_flag, tx_act_r;
    logic [8:0]  txb_data_r;
    logic        hold_valid_r, dor_pend_r;
    logic [uart_buf_pkg::ENT_W-1:0] hold_r;
    logic [uart_buf_pkg::ENT_W-1:0] fifo_r [RX_DEPTH];
    logic [PW-1:0] rd_ptr_r, wr_ptr_r;
    logic [PW:0]   cnt_r;
    // Synchronisers
    logic rxd_s1, rxd_s2, xck_s1, xck_s2, xck_s3;

    logic wr_en, rd_now, pop, push, nine, tx_done, start_det;
    logic tx_empty_flag, rx_complete_flag;
    logic [3:0] last_idx;
    logic [7:0] data_mask;
    logic [8:0] mask9;
    logic [uart_buf_pkg::ENT_W-1:0] head;

    assign nine      = {size2_r, size_lo_r} == uart_buf_pkg::SIZE_NINE;
    assign last_idx  = nine ? 4'h8 : {2'h0, size_lo_r} + 4'h4;
    assign data_mask = nine ? 8'hff : 8'hff >> (2'h3 - size_lo_r);
    assign mask9     = {nine, data_mask};
    // Empty buffer shows zero status, never a stale or unwritten entry
    assign head      = (cnt_r != '0) ? fifo_r[rd_ptr_r] : '0;

    // Bus: writes take effect in their data phase, reads add one wait
    assign wr_en     = dp_valid_r && dp_write_r;
    assign rd_now    = dp_valid_r && !dp_write_r && !rd_done_r;
    assign hreadyout = !rd_now;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r  <= 5'h00;
            rd_done_r  <= 1'b0;
        end else if (hready) begin
            dp_valid_r <= hsel && htrans[1];
            dp_write_r <= hwrite;
            dp_addr_r  <= {haddr[4:2], 2'h0};
            rd_done_r  <= 1'b0;
        end else if (rd_now) begin
            rd_done_r  <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_now) begin
            hrdata_r <= 32'h0000_0000;
            case (dp_addr_r)
                uart_buf_pkg::OFF_DATA:
                    hrdata_r[7:0] <= (cnt_r != '0) ?
                        head[10:3] & data_mask : 8'h00;
                uart_buf_pkg::OFF_STAT_A: begin
                    hrdata_r[uart_buf_pkg::A_RXC] <= rx_complete_flag;
                    hrdata_r[uart_buf_pkg::A_TXC] <= tx_complete_flag;
                    hrdata_r[uart_buf_pkg::A_TXE] <= tx_empty_flag;
                    hrdata_r[uart_buf_pkg::A_FE]  <= head[2];
                    hrdata_r[uart_buf_pkg::A_DOR] <= head[1];
                    hrdata_r[uart_buf_pkg::A_PE]  <= head[0];
                end
                uart_buf_pkg::OFF_STAT_B:
                    hrdata_r[7:0] <= {rxcie_r, txcie_r, txeie_r, rx_en_r,
                                      tx_en_r, size2_r, head[11], tx9_r};
                uart_buf_pkg::OFF_FRAME:
                    hrdata_r[5:0] <= {sync_r, size_lo_r, stop2_r,
                                      par_en_r, par_odd_r};
                uart_buf_pkg::OFF_BAUD:
                    hrdata_r[11:0] <= baud_r;
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {rxcie_r, txcie_r, txeie_r, rx_en_r, tx_en_r} <= 5'h00;
            {size2_r, tx9_r, par_en_r, par_odd_r, stop2_r} <= 5'h00;
            sync_r    <= 1'b0;
            size_lo_r <= uart_buf_pkg::SIZE_LO_RST;
            baud_r    <= uart_buf_pkg::BAUD_RST;
        end else if (wr_en) begin
            case (dp_addr_r)
                uart_buf_pkg::OFF_STAT_B: begin
                    rxcie_r <= hwdata[uart_buf_pkg::B_RXCIE];
                    txcie_r <= hwdata[uart_buf_pkg::B_TXCIE];
                    txeie_r <= hwdata[uart_buf_pkg::B_TXEIE];
                    rx_en_r <= hwdata[uart_buf_pkg::B_RXEN];
                    tx_en_r <= hwdata[uart_buf_pkg::B_TXEN];
                    size2_r <= hwdata[uart_buf_pkg::B_SIZE2];
                    tx9_r   <= hwdata[uart_buf_pkg::B_TX9];
                end
                uart_buf_pkg::OFF_FRAME: begin
                    par_odd_r <= hwdata[uart_buf_pkg::F_PODD];
                    par_en_r  <= hwdata[uart_buf_pkg::F_PEN];
                    stop2_r   <= hwdata[uart_buf_pkg::F_STOP2];
                    size_lo_r <= hwdata[uart_buf_pkg::F_SIZE +: 2];
                    sync_r    <= hwdata[uart_buf_pkg::F_SYNC];
                end
                uart_buf_pkg::OFF_BAUD: baud_r <= hwdata[11:0];
                default: ;
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {rxd_s1, rxd_s2} <= 2'h3;
            {xck_s1, xck_s2, xck_s3} <= 3'h0;
        end else begin
            rxd_s1 <= serial_in_pin;
            rxd_s2 <= rxd_s1;
            xck_s1 <= transfer_clock_pin;
            xck_s2 <= xck_s1;
            xck_s3 <= xck_s2;
        end
    end

    // Transmit buffer and flags
    logic tx_load, tx_wr;
    uart_buf_pkg::tx_st_e tx_st_r;
    assign tx_wr   = wr_en && dp_addr_r == uart_buf_pkg::OFF_DATA;
    assign tx_load = tx_act_r && txb_valid_r &&
                     tx_st_r == uart_buf_pkg::TX_IDLE;
    assign tx_empty_flag = !txb_valid_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txb_valid_r <= 1'b0;
            txb_data_r  <= 9'h000;
        end else if (tx_wr) begin
            txb_valid_r <= 1'b1;
            txb_data_r  <= {tx9_r, hwdata[7:0]};
        end else if (tx_load) begin
            txb_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_complete_flag <= 1'b0;
        end else if (tx_done && !txb_valid_r) begin
            tx_complete_flag <= 1'b1;
        end else if (tx_complete_irq_ack ||
                     (wr_en && dp_addr_r == uart_buf_pkg::OFF_STAT_A &&
                      hwdata[uart_buf_pkg::A_TXC])) begin
            tx_complete_flag <= 1'b0;
        end
    end

    // Deferred disable: hold the pin until shifter and buffer drain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_act_r <= 1'b0;
        end else if (tx_en_r) begin
            tx_act_r <= 1'b1;
        end else if (!txb_valid_r && !tx_wr &&
                     tx_st_r == uart_buf_pkg::TX_IDLE) begin
            tx_act_r <= 1'b0;
        end
    end
    assign serial_out_oe = tx_act_r;

    // Transmit shifter
    logic [11:0] tx_cnt_r;
    logic [8:0]  tx_sh_r;
    logic [3:0]  tx_bit_r;
    logic        tx_par_r, tx_line_r, tx_stop_r, tx_tick;
    assign tx_tick = sync_r ? (!xck_s2 && xck_s3) : tx_cnt_r == baud_r;
    assign tx_done = tx_tick && tx_st_r == uart_buf_pkg::TX_STOP &&
                     !(stop2_r && !tx_stop_r);
    assign serial_out_pin = tx_line_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_st_r   <= uart_buf_pkg::TX_IDLE;
            tx_cnt_r  <= 12'h000;
            tx_sh_r   <= 9'h000;
            tx_bit_r  <= 4'h0;
            tx_par_r  <= 1'b0;
            tx_line_r <= 1'b1;
            tx_stop_r <= 1'b0;
        end else begin
            tx_cnt_r <= (tx_tick || tx_load) ? 12'h000 : tx_cnt_r + 12'h001;
            case (tx_st_r)
                uart_buf_pkg::TX_IDLE: if (tx_load) begin
                    tx_st_r   <= uart_buf_pkg::TX_START;
                    tx_sh_r   <= txb_data_r & mask9;
                    tx_par_r  <= ^(txb_data_r & mask9) ^ par_odd_r;
                    tx_bit_r  <= 4'h0;
                    tx_line_r <= 1'b0;
                end
                uart_buf_pkg::TX_START: if (tx_tick) begin
                    tx_st_r   <= uart_buf_pkg::TX_DATA;
                    tx_line_r <= tx_sh_r[0];
                end
                uart_buf_pkg::TX_DATA: if (tx_tick) begin
                    if (tx_bit_r == last_idx) begin
                        tx_st_r   <= par_en_r ? uart_buf_pkg::TX_PAR
                                              : uart_buf_pkg::TX_STOP;
                        tx_line_r <= par_en_r ? tx_par_r : 1'b1;
                        tx_stop_r <= 1'b0;
                    end else begin
                        tx_sh_r   <= tx_sh_r >> 1;
                        tx_line_r <= tx_sh_r[1];
                        tx_bit_r  <= tx_bit_r + 4'h1;
                    end
                end
                uart_buf_pkg::TX_PAR: if (tx_tick) begin
                    tx_st_r   <= uart_buf_pkg::TX_STOP;
                    tx_line_r <= 1'b1;
                end
                uart_buf_pkg::TX_STOP: if (tx_tick) begin
                    tx_stop_r <= 1'b1;
                    if (tx_done) tx_st_r <= uart_buf_pkg::TX_IDLE;
                end
                default: tx_st_r <= uart_buf_pkg::TX_IDLE;
            endcase
        end
    end

    // Receiver: pin taken only while enabled
    uart_buf_pkg::rx_st_e rx_st_r;
    logic [11:0] rx_cnt_r;
    logic [8:0]  rx_sh_r;
    logic [3:0]  rx_bit_r;
    logic        rx_par_r, rx_samp, rx_in, rx_end;
    assign serial_in_takeover = rx_en_r;
    assign rx_in   = rxd_s2;
    assign rx_samp = sync_r ? (xck_s2 && !xck_s3)
                            : rx_cnt_r == baud_r;
    assign start_det = rx_en_r && !rx_in && (sync_r ?
        (rx_st_r == uart_buf_pkg::RX_IDLE && xck_s2 && !xck_s3) :
        (rx_st_r == uart_buf_pkg::RX_START && rx_cnt_r == baud_r >> 1));
    assign rx_end = rx_samp && rx_st_r == uart_buf_pkg::RX_STOP;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_st_r  <= uart_buf_pkg::RX_IDLE;
            rx_cnt_r <= 12'h000;
            rx_sh_r  <= 9'h000;
            rx_bit_r <= 4'h0;
            rx_par_r <= 1'b0;
        end else if (!rx_en_r) begin
            rx_st_r  <= uart_buf_pkg::RX_IDLE;
            rx_cnt_r <= 12'h000;
        end else begin
            rx_cnt_r <= (rx_samp || start_det) ? 12'h000 : rx_cnt_r + 12'h001;
            case (rx_st_r)
                uart_buf_pkg::RX_IDLE: begin
                    rx_sh_r  <= 9'h000;
                    rx_bit_r <= 4'h0;
                    if (start_det) rx_st_r <= uart_buf_pkg::RX_DATA;
                    else if (!sync_r && !rx_in) begin
                        rx_st_r  <= uart_buf_pkg::RX_START;
                        rx_cnt_r <= 12'h000;
                    end
                end
                uart_buf_pkg::RX_START:
                    if (rx_cnt_r == baud_r >> 1)
                        rx_st_r <= start_det ? uart_buf_pkg::RX_DATA
                                             : uart_buf_pkg::RX_IDLE;
                uart_buf_pkg::RX_DATA: if (rx_samp) begin
                    rx_sh_r[rx_bit_r] <= rx_in;
                    rx_bit_r <= rx_bit_r + 4'h1;
                    if (rx_bit_r == last_idx)
                        rx_st_r <= par_en_r ? uart_buf_pkg::RX_PAR
                                            : uart_buf_pkg::RX_STOP;
                end
                uart_buf_pkg::RX_PAR: if (rx_samp) begin
                    rx_par_r <= rx_in;
                    rx_st_r  <= uart_buf_pkg::RX_STOP;
                end
                // Back to idle on the first stop; a second is never waited
                uart_buf_pkg::RX_STOP:
                    if (rx_samp) rx_st_r <= uart_buf_pkg::RX_IDLE;
                default: rx_st_r <= uart_buf_pkg::RX_IDLE;
            endcase
        end
    end

    // Waiting frame in the shift stage, then the RX_DEPTH-entry buffer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_valid_r <= 1'b0;
            hold_r       <= '0;
            dor_pend_r   <= 1'b0;
        end else if (!rx_en_r) begin
            hold_valid_r <= 1'b0;
            dor_pend_r   <= 1'b0;
        end else begin
            if (start_det && cnt_r == DEPTH_C && hold_valid_r)
                dor_pend_r <= 1'b1;
            if (rx_end) begin
                hold_valid_r <= 1'b1;
                dor_pend_r   <= 1'b0;
                hold_r <= {nine & rx_sh_r[8], rx_sh_r[7:0] & data_mask,
                           !rx_in, dor_pend_r, par_en_r &
                           (^(rx_sh_r & mask9) ^ par_odd_r ^ rx_par_r)};
            end else if (push) begin
                hold_valid_r <= 1'b0;
            end
        end
    end

    assign pop  = rd_now && dp_addr_r == uart_buf_pkg::OFF_DATA && cnt_r != '0;
    assign push = hold_valid_r && !rx_end && (cnt_r != DEPTH_C || pop);
    assign rx_complete_flag = cnt_r != '0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            cnt_r    <= '0;
        end else if (!rx_en_r) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (pop) rd_ptr_r <= rd_ptr_r + PW'(1);
            if (push) wr_ptr_r <= wr_ptr_r + PW'(1);
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Entries hold no control state, so no reset is needed
    always_ff @(posedge ref_clk) begin
        if (push) fifo_r[wr_ptr_r] <= hold_r;
    end

    // Level requests; global gating lives in the interrupt controller
    assign tx_empty_irq    = tx_empty_flag && txeie_r;
    assign tx_complete_irq = tx_complete_flag && txcie_r;
    assign rx_complete_irq = rx_complete_flag && rxcie_r;

    txe_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        tx_wr |=> !tx_empty_flag)
        else $error("data write left transmit-empty set");
    txe_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
        txeie_r && tx_empty_flag && $past(tx_empty_flag) |-> tx_empty_irq)
        else $error("transmit-empty request dropped");
    txc_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        tx_done && !txb_valid_r |=> tx_complete_flag ##0
        (tx_complete_irq == txcie_r))
        else $error("transmit-complete not set at frame end");
    txc_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
        tx_complete_irq_ack && !tx_done |=> !tx_complete_flag)
        else $error("transmit-complete not cleared by service");
    tx_par_a: assert property (@(posedge ref_clk) disable iff (rst)
        tx_st_r == uart_buf_pkg::TX_DATA && tx_tick &&
        tx_bit_r == last_idx && par_en_r |=>
        tx_st_r == uart_buf_pkg::TX_PAR && serial_out_pin == tx_par_r)
        else $error("parity bit not inserted");
    tx_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(serial_out_oe) |-> !txb_valid_r &&
        tx_st_r == uart_buf_pkg::TX_IDLE && !tx_en_r)
        else $error("transmitter released with data pending");
    rx_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
        !rx_en_r |-> !serial_in_takeover ##1 !rx_complete_flag)
        else $error("receive buffer not flushed");
    rx_pop_a: assert property (@(posedge ref_clk) disable iff (rst)
        pop && cnt_r == 1 && !push |=> !rx_complete_flag ##0 !rx_complete_irq)
        else $error("read did not advance the buffer");
    rx_ovr_a: assert property (@(posedge ref_clk) disable iff (rst)
        start_det && cnt_r == DEPTH_C && hold_valid_r |=> dor_pend_r)
        else $error("overrun not flagged");
    bus_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_now |-> !hreadyout ##1 hreadyout)
        else $error("read wait not exactly one cycle");

    tx_frame_c: cover property (@(posedge ref_clk) disable iff (rst)
        tx_done ##1 tx_complete_flag);
    rx_full_c: cover property (@(posedge ref_clk) disable iff (rst)
        cnt_r == DEPTH_C && hold_valid_r);
    tx_defer_c: cover property (@(posedge ref_clk) disable iff (rst)
        !tx_en_r && tx_act_r && tx_st_r != uart_buf_pkg::TX_IDLE);
endmodule : uart_buffer_flags_and_irqs

// >>> tb/serial_node.sv
`timescale 1ns/1ns
module serial_node #(
    parameter int BIT = 4
) (
    // Line side
    input  wire logic ref_clk,
    input  wire logic tx_line,
    output logic      rx_line,
    output logic      xck_line
);
    // Idle line is high between frames; transfer clock rests low
    initial rx_line = 1'b1;
    initial xck_line = 1'b0;
    // Data set up while the clock is low, taken on its rise
    task automatic send_sync(input logic [8:0] f);
        for (int i = 0; i < 11; i++) begin
            rx_line <= (i == 0) ? 1'b0 : (i < 10) ? f[i-1] : 1'b1;
            repeat (BIT) @(posedge ref_clk);
            xck_line <= 1'b1;
            repeat (BIT) @(posedge ref_clk);
            xck_line <= 1'b0;
        end
    endtask : send_sync
    task automatic send(input logic [8:0] f);
        rx_line <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge ref_clk);
            rx_line <= (i < 9) ? f[i] : 1'b1;
        end
        repeat (BIT) @(posedge ref_clk);
    endtask : send
    // Samples near bit centres: start found, then half a bit
    task automatic grab(output logic [9:0] f);
        while (tx_line !== 1'b0) @(posedge ref_clk);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge ref_clk);
            f[i] = tx_line;
        end
    endtask : grab
endmodule : serial_node

// >>> tb/uart_buffer_flags_and_irqs_tb.sv
`timescale 1ns/1ns
module uart_buffer_flags_and_irqs_tb;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        tx_complete_irq_ack = 1'b0;
    logic [1:0]  htrans  = 2'b00;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] seed    = 32'h0000_0024;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, rxd, txd, oe, take, odd, xck;
    logic        txe_irq, txc_irq, rxc_irq;
    logic [7:0]  d0, d1;
    logic [9:0]  f0, f1;
    int          err_count = 0;
    int          n_checks  = 0;
    always #2 ref_clk = ~ref_clk;
    uart_buffer_flags_and_irqs i_dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(rxd),
        .transfer_clock_pin(xck), .serial_out_pin(txd),
        .serial_out_oe(oe), .serial_in_takeover(take),
        .tx_complete_irq_ack(tx_complete_irq_ack),
        .tx_empty_irq(txe_irq), .tx_complete_irq(txc_irq),
        .rx_complete_irq(rxc_irq));
    serial_node i_node (.ref_clk(ref_clk), .tx_line(txd), .rx_line(rxd),
        .xck_line(xck));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic par(input logic [7:0] d, input logic o);
        return ^d ^ o;
    endfunction : par
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Single word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'b10, w};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        // Register effects settle before callers look at levels
        #1;
    endtask : bus
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        odd = rnd() & 1;
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_0020, q);
        chk("txe_irq", 0, txe_irq);
        bus(uart_buf_pkg::OFF_FRAME, 1, 32'h0000_001a | odd, q);
        bus(uart_buf_pkg::OFF_BAUD, 1, 32'h0000_0003, q);
        for (int k = 0; k < 2; k++) begin
            bus(uart_buf_pkg::OFF_STAT_B, 1, 32'h0000_00f8, q);
            chk("txe_irq", 1, txe_irq);
            chk("take", 1, take);
            d0 = rnd();
            d1 = rnd();
            fork
                begin
                    bus(uart_buf_pkg::OFF_DATA, 1, d0, q);
                    bus(uart_buf_pkg::OFF_DATA, 1, d1, q);
                    bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
                    chk("stat_a", 32'h0000_0000, q);
                    bus(uart_buf_pkg::OFF_STAT_B, 1, 32'h0000_00f0, q);
                    chk("oe", 1, oe);
                end
                begin
                    i_node.grab(f0);
                    i_node.grab(f1);
                end
            join
            chk("frame", {1'b1, par(d0, odd), d0}, f0);
            chk("frame", {1'b1, par(d1, odd), d1}, f1);
            repeat (8) @(posedge ref_clk);
            bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
            chk("stat_a", 32'h0000_0060, q);
            chk("txc_irq", 1, txc_irq);
            chk("oe", 0, oe);
            if (k == 0) begin
                tx_complete_irq_ack <= 1'b1;
                @(posedge ref_clk);
                tx_complete_irq_ack <= 1'b0;
            end else
                bus(uart_buf_pkg::OFF_STAT_A, 1, 32'h0000_0040, q);
            bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
            chk("stat_a", 32'h0000_0020, q);
        end
        i_node.send({par(d0, odd), d0});
        i_node.send({par(d1, odd), d1});
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_00a0, q);
        chk("rxc_irq", 1, rxc_irq);
        bus(uart_buf_pkg::OFF_DATA, 0, 0, q);
        chk("data", d0, q);
        bus(uart_buf_pkg::OFF_DATA, 0, 0, q);
        chk("data", d1, q);
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_0020, q);
        i_node.send({~par(d0, odd), d0});
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_00a4, q);
        repeat (3) i_node.send({par(d1, odd), d1});
        bus(uart_buf_pkg::OFF_DATA, 0, 0, q);
        chk("data", d0, q);
        bus(uart_buf_pkg::OFF_DATA, 0, 0, q);
        chk("data", d1, q);
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_00a8, q);
        bus(uart_buf_pkg::OFF_STAT_B, 1, 0, q);
        bus(uart_buf_pkg::OFF_STAT_A, 0, 0, q);
        chk("stat_a", 32'h0000_0020, q);
        chk("take", 0, take);
        bus(uart_buf_pkg::OFF_FRAME, 1, 32'h0000_003a | odd, q);
        bus(uart_buf_pkg::OFF_STAT_B, 1, 32'h0000_0010, q);
        i_node.send_sync({par(d0, odd), d0});
        bus(uart_buf_pkg::OFF_DATA, 0, 0, q);
        chk("data", d0, q);
        print_verdict();
    end
endmodule : uart_buffer_flags_and_irqs_tb
